// ### shared/smcw_defs.svh
`ifndef SMCW_DEFS_SVH
`define SMCW_DEFS_SVH

// Bank count and configuration word size
`define SMCW_BANKS          8
`define SMCW_CFG_W          32

// Configuration word fields
`define SMCW_F_WIDTH_LO     0
`define SMCW_F_WIDTH_HI     1
`define SMCW_F_BURST        2
`define SMCW_F_WPROT        3
`define SMCW_F_CSPOL        4
`define SMCW_F_WAITEN       5
`define SMCW_F_WAITPOL      6
`define SMCW_F_RBLE         7
`define SMCW_F_TURN_LO      8
`define SMCW_F_TURN_HI      11
`define SMCW_F_DLY_LO       12
`define SMCW_F_DLY_HI       15
`define SMCW_F_WSTR_LO      16
`define SMCW_F_WSTR_HI      20
`define SMCW_F_WSTW_LO      21
`define SMCW_F_WSTW_HI      25
`define SMCW_F_WSTB_LO      26
`define SMCW_F_WSTB_HI      30

// Reset value of a bank word: 32-bit path, everything else off
`define SMCW_CFG_RESET      32'h00000002

// External data path width codes
`define SMCW_W8             2'h0
`define SMCW_W16            2'h1
`define SMCW_W32            2'h2

// Bus codes
`define SMCW_HRESP_OKAY     2'h0
`define SMCW_HRESP_ERROR    2'h1
`define SMCW_HTRANS_SEQ     2'h3

// Address split
`define SMCW_BANK_HI        28
`define SMCW_BANK_LO        26
`define SMCW_OFS_HI         25

// Timing counts in clock cycles
`define SMCW_BOOT_CYCLES    3'h3
`define SMCW_RCAP_LOAD      5'h01
`define SMCW_WAIT_BLANK     2'h1
`define SMCW_WAIT_MIN_SW    5'h03

`endif

// ### shared/smcw_pkg.sv
package smcw_pkg;

  typedef enum logic [3:0] {
    ST_BOOT,
    ST_IDLE,
    ST_CFG,
    ST_TURN,
    ST_DLY,
    ST_ACC,
    ST_XWAIT,
    ST_RCAP,
    ST_NEXT,
    ST_ERR1,
    ST_ERR2
  } smcw_state_t;

endpackage

// ### logic/smcw_cfg_mem.sv
module smcw_cfg_mem #(
  parameter int               DEPTH     = 8,
  parameter int               WIDTH     = 32,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Registered read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= RESET_VAL;
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= RESET_VAL;
    end else begin
      rd_data <= mem_ff[rd_addr];
    end
  end

endmodule

// ### logic/smcw_static_mem_ctrl.sv
`include "smcw_defs.svh"

module smcw_static_mem_ctrl
  import smcw_pkg::*;
#(
  parameter int BANKS = `SMCW_BANKS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // System bus slave
  input  wire logic        memory_space_select,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [28:0] haddr,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready_in,
  output logic             hready_out,
  output logic      [31:0] hrdata,
  output logic      [1:0]  hresp,
  // Bank configuration write port
  input  wire logic        cfg_wr_en,
  input  wire logic [2:0]  cfg_wr_bank,
  input  wire logic [31:0] cfg_wr_data,
  // Strap pins
  input  wire logic [1:0]  boot_width_strap,
  input  wire logic        endian_select,
  // External memory bus
  output logic      [BANKS-1:0] bank_chip_select,
  output logic      [25:0] mem_addr,
  output logic             mem_output_strobe_n,
  output logic             mem_write_strobe_n,
  output logic      [3:0]  byte_lane_select_n,
  input  wire logic [31:0] mem_data_in,
  output logic      [31:0] mem_data_out,
  output logic             mem_data_oe_n,
  input  wire logic        ext_wait_in,
  // Status
  output logic             busy
);

  smcw_state_t state_ff, nxt_state;
  logic [35:0] sync1_ff, sync2_ff;
  logic [4:0]  cnt_ff, nxt_cnt, wst_cur_ff, wst_sel;
  logic [1:0]  beat_ff, nxt_beat, cs_age_ff, size_ff, beats_m1;
  logic [2:0]  boot_cnt_ff, bank_ff, last_bank_ff, nbytes, wbytes, off_tmp;
  logic [25:0] addr_ff, byte_addr, ext_addr;
  logic [31:0] cur_cfg_ff, cfg_now, cfg_rd_data, wdata_ff, wsrc, rd_shift, wr_cfg;
  logic        write_ff, seq_ff, last_write_ff, have_last_ff, subseq_ff, nxt_subseq, subseq_eff;
  logic        boot_wr, accept, wait_act, wait_seen, need_turn, burst_cont, cap;
  logic        cs_on, strobe_nx, in_beat_c, nxt_in_beat;
  logic [1:0]  f_width, eff_off, lane_base, ext_base, lane_in_ext;
  logic [3:0]  f_turn, f_dly, ones, ext_mask, word_mask;
  logic [BANKS-1:0] cs_pol_ff, nxt_cs;
  logic [7:0]  rdata_ff [4];
  logic        wait_s2, endian_s2;
  logic [1:0]  strap_s2;
  logic [31:0] data_s2;

  // Pin synchroniser: first stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= 36'h000000000;
      sync2_ff <= 36'h000000000;
    end else begin
      sync1_ff <= {ext_wait_in, endian_select, boot_width_strap, mem_data_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign wait_s2   = sync2_ff[35];
  assign endian_s2 = sync2_ff[34];
  assign strap_s2  = sync2_ff[33:32];
  assign data_s2   = sync2_ff[31:0];

  assign wr_cfg = boot_wr ? ((`SMCW_CFG_RESET & ~32'h00000003) | {30'h00000000, strap_s2}) : cfg_wr_data;

  smcw_cfg_mem #(
    .DEPTH     (BANKS),
    .WIDTH     (`SMCW_CFG_W),
    .RESET_VAL (`SMCW_CFG_RESET)
  ) u_cfg_mem (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (boot_wr | cfg_wr_en),
    .wr_addr (boot_wr ? 3'h0 : cfg_wr_bank),
    .wr_data (wr_cfg),
    .rd_addr (haddr[`SMCW_BANK_HI:`SMCW_BANK_LO]),
    .rd_data (cfg_rd_data)
  );

  // Per-bank settings, taken fresh in the config cycle
  assign cfg_now  = (state_ff == ST_CFG) ? cfg_rd_data : cur_cfg_ff;
  assign f_width  = cfg_now[`SMCW_F_WIDTH_HI:`SMCW_F_WIDTH_LO];
  assign f_turn   = cfg_now[`SMCW_F_TURN_HI:`SMCW_F_TURN_LO];
  assign f_dly    = cfg_now[`SMCW_F_DLY_HI:`SMCW_F_DLY_LO];
  assign wait_act = cfg_now[`SMCW_F_WAITEN] && (wait_s2 == cfg_now[`SMCW_F_WAITPOL]);
  assign wait_seen = wait_act && (cs_age_ff >= `SMCW_WAIT_BLANK);

  assign accept = memory_space_select && hready_in && htrans[1] && (state_ff == ST_IDLE || state_ff == ST_ERR2);
  assign need_turn = have_last_ff && (f_turn != 4'h0)
                     && (bank_ff != last_bank_ff || write_ff != last_write_ff);
  assign burst_cont = seq_ff && cfg_now[`SMCW_F_BURST] && !write_ff && have_last_ff
                      && !last_write_ff && bank_ff == last_bank_ff;
  assign subseq_eff = (state_ff == ST_CFG) ? burst_cont : (state_ff == ST_NEXT) ? 1'b1 : subseq_ff;

  // Wait count for the beat about to start
  always_comb begin
    if (write_ff) begin
      wst_sel = cfg_now[`SMCW_F_WSTW_HI:`SMCW_F_WSTW_LO];
    end else if (cfg_now[`SMCW_F_BURST] && subseq_eff) begin
      wst_sel = cfg_now[`SMCW_F_WSTB_HI:`SMCW_F_WSTB_LO];
    end else begin
      wst_sel = cfg_now[`SMCW_F_WSTR_HI:`SMCW_F_WSTR_LO];
    end
  end

  // Transfer sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_beat   = beat_ff;
    nxt_subseq = subseq_ff;
    boot_wr    = 1'b0;
    case (state_ff)
      ST_BOOT: begin
        if (boot_cnt_ff == `SMCW_BOOT_CYCLES) begin
          boot_wr   = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE, ST_ERR2: begin
        nxt_state = accept ? ST_CFG : ST_IDLE;
      end
      ST_CFG, ST_TURN, ST_NEXT: begin
        if (state_ff == ST_CFG) begin
          nxt_beat   = 2'h0;
          nxt_subseq = burst_cont;
        end
        if (state_ff == ST_CFG && write_ff && cfg_now[`SMCW_F_WPROT]) begin
          nxt_state = ST_ERR1;
        end else if (state_ff == ST_CFG && need_turn) begin
          nxt_state = ST_TURN;
          nxt_cnt   = {1'b0, f_turn - 4'h1};
        end else if (state_ff == ST_TURN && cnt_ff != 5'h00) begin
          nxt_cnt = cnt_ff - 5'h01;
        end else if (state_ff == ST_NEXT && beat_ff == beats_m1) begin
          nxt_state = ST_IDLE;
        end else begin
          if (state_ff == ST_NEXT) begin
            nxt_beat   = beat_ff + 2'h1;
            nxt_subseq = 1'b1;
          end
          nxt_state = (f_dly != 4'h0) ? ST_DLY : ST_ACC;
          nxt_cnt   = (f_dly != 4'h0) ? {1'b0, f_dly - 4'h1} : wst_sel;
        end
      end
      ST_DLY: begin
        if (cnt_ff == 5'h00) begin
          nxt_state = ST_ACC;
          nxt_cnt   = wst_sel;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      ST_ACC: begin
        if (wait_seen) begin
          nxt_state = ST_XWAIT;
        end else if (cnt_ff == 5'h00) begin
          nxt_state = write_ff ? ST_NEXT : ST_RCAP;
          nxt_cnt   = `SMCW_RCAP_LOAD;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      ST_XWAIT: begin
        if (!wait_act) begin
          nxt_state = write_ff ? ST_NEXT : ST_RCAP;
          nxt_cnt   = `SMCW_RCAP_LOAD;
        end
      end
      ST_RCAP: begin
        if (cnt_ff == 5'h00) begin
          nxt_state = ST_NEXT;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      ST_ERR1: begin
        nxt_state = ST_ERR2;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff   <= ST_BOOT;
      cnt_ff     <= 5'h00;
      beat_ff    <= 2'h0;
      subseq_ff  <= 1'b0;
      wst_cur_ff <= 5'h00;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      beat_ff   <= nxt_beat;
      subseq_ff <= nxt_subseq;
      if (nxt_state == ST_ACC && state_ff != ST_ACC) begin
        wst_cur_ff <= wst_sel;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_cnt_ff <= 3'h0;
    end else if (state_ff == ST_BOOT) begin
      boot_cnt_ff <= boot_cnt_ff + 3'h1;
    end
  end

  // Cycles since chip select rose within a beat
  assign in_beat_c = state_ff == ST_DLY || state_ff == ST_ACC || state_ff == ST_XWAIT || state_ff == ST_RCAP;
  assign nxt_in_beat = nxt_state == ST_DLY || nxt_state == ST_ACC || nxt_state == ST_XWAIT || nxt_state == ST_RCAP;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_age_ff <= 2'h0;
    end else if (in_beat_c && nxt_in_beat) begin
      cs_age_ff <= (cs_age_ff == 2'h3) ? cs_age_ff : cs_age_ff + 2'h1;
    end else begin
      cs_age_ff <= 2'h0;
    end
  end

  // Request capture and history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bank_ff       <= 3'h0;
      addr_ff       <= 26'h0000000;
      write_ff      <= 1'b0;
      size_ff       <= 2'h0;
      seq_ff        <= 1'b0;
      cur_cfg_ff    <= `SMCW_CFG_RESET;
      wdata_ff      <= 32'h00000000;
      last_bank_ff  <= 3'h0;
      last_write_ff <= 1'b0;
      have_last_ff  <= 1'b0;
    end else begin
      if (accept) begin
        bank_ff  <= haddr[`SMCW_BANK_HI:`SMCW_BANK_LO];
        addr_ff  <= haddr[`SMCW_OFS_HI:0];
        write_ff <= hwrite;
        size_ff  <= (hsize > 3'h2) ? 2'h2 : hsize[1:0];
        seq_ff   <= (htrans == `SMCW_HTRANS_SEQ);
      end
      if (state_ff == ST_CFG) begin
        cur_cfg_ff <= cfg_rd_data;
        wdata_ff   <= hwdata;
      end
      if (state_ff == ST_NEXT && nxt_state == ST_IDLE) begin
        last_bank_ff  <= bank_ff;
        last_write_ff <= write_ff;
        have_last_ff  <= 1'b1;
      end
    end
  end

  // Beat geometry: lanes, address and data shift
  always_comb begin
    nbytes   = (size_ff == 2'h0) ? 3'h1 : (size_ff == 2'h1) ? 3'h2 : 3'h4;
    wbytes   = (f_width == `SMCW_W8) ? 3'h1 : (f_width == `SMCW_W16) ? 3'h2 : 3'h4;
    beats_m1 = (wbytes >= nbytes) ? 2'h0 : (nbytes == 3'h4 && wbytes == 3'h1) ? 2'h3 : 2'h1;
    off_tmp  = 3'h4 - nbytes;
    eff_off  = endian_s2 ? (off_tmp[1:0] - addr_ff[1:0]) : addr_ff[1:0];
    case (wbytes)
      3'h1:    lane_base = eff_off + nxt_beat;
      3'h2:    lane_base = eff_off + {nxt_beat[0], 1'b0};
      default: lane_base = eff_off;
    endcase
    case (wbytes)
      3'h1:    ext_base = lane_base;
      3'h2:    ext_base = {lane_base[1], 1'b0};
      default: ext_base = 2'h0;
    endcase
    lane_in_ext = lane_base - ext_base;
    ones        = (nbytes < wbytes) ? ((nbytes == 3'h1) ? 4'h1 : 4'h3) : ((wbytes == 3'h1) ? 4'h1 :
                  (wbytes == 3'h2) ? 4'h3 : 4'hF);
    ext_mask    = ones << lane_in_ext;
    word_mask   = ext_mask << ext_base;
    byte_addr   = {addr_ff[`SMCW_OFS_HI:2], lane_base};
    case (wbytes)
      3'h1:    ext_addr = byte_addr;
      3'h2:    ext_addr = {1'b0, byte_addr[25:1]};
      default: ext_addr = {2'h0, byte_addr[25:2]};
    endcase
    wsrc     = (state_ff == ST_CFG) ? hwdata : wdata_ff;
    rd_shift = data_s2 << {ext_base, 3'h0};
  end

  assign cap = (state_ff == ST_RCAP) && (cnt_ff == 5'h00);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          rdata_ff[g] <= 8'h00;
        end else if (state_ff == ST_CFG) begin
          rdata_ff[g] <= 8'h00;
        end else if (cap && word_mask[g]) begin
          rdata_ff[g] <= rd_shift[g*8 +: 8];
        end
      end
    end
    for (g = 0; g < BANKS; g++) begin : g_cs
      assign nxt_cs[g] = ~((cs_on && bank_ff == 3'(g)) ^ cs_pol_ff[g]);
    end
  endgenerate

  // Chip select polarities kept apart so idle banks show theirs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_pol_ff <= '0;
    end else if (cfg_wr_en && !boot_wr) begin
      cs_pol_ff[cfg_wr_bank] <= cfg_wr_data[`SMCW_F_CSPOL];
    end
  end

  // Pin registers follow the next state so pins line up with it
  assign cs_on     = nxt_in_beat || nxt_state == ST_NEXT;
  assign strobe_nx = nxt_state == ST_ACC || nxt_state == ST_XWAIT || nxt_state == ST_RCAP;

  logic [BANKS-1:0] bank_chip_select_ff;
  logic [25:0]      mem_addr_ff;
  logic [31:0]      mem_data_out_ff;
  logic [3:0]       byte_lane_select_n_ff;
  logic [1:0]       hresp_ff;
  logic             mem_output_strobe_n_ff, mem_write_strobe_n_ff, mem_data_oe_n_ff, hready_out_ff, busy_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bank_chip_select_ff    <= {BANKS{1'b1}};
      mem_addr_ff            <= 26'h0000000;
      mem_data_out_ff        <= 32'h00000000;
      byte_lane_select_n_ff  <= 4'hF;
      mem_output_strobe_n_ff <= 1'b1;
      mem_write_strobe_n_ff  <= 1'b1;
      mem_data_oe_n_ff       <= 1'b1;
      hready_out_ff          <= 1'b0;
      hresp_ff               <= `SMCW_HRESP_OKAY;
      busy_ff                <= 1'b1;
    end else begin
      bank_chip_select_ff    <= nxt_cs;
      mem_output_strobe_n_ff <= !(strobe_nx && !write_ff);
      mem_write_strobe_n_ff  <= !(strobe_nx && write_ff);
      mem_data_oe_n_ff       <= !(cs_on && write_ff);
      byte_lane_select_n_ff  <= (cs_on && (write_ff || cfg_now[`SMCW_F_RBLE])) ? ~ext_mask : 4'hF;
      if (cs_on) begin
        mem_addr_ff     <= ext_addr;
        mem_data_out_ff <= wsrc >> {ext_base, 3'h0};
      end
      hready_out_ff <= (nxt_state == ST_IDLE || nxt_state == ST_ERR2);
      hresp_ff      <= (nxt_state == ST_ERR1 || nxt_state == ST_ERR2) ? `SMCW_HRESP_ERROR : `SMCW_HRESP_OKAY;
      busy_ff       <= (nxt_state != ST_IDLE);
    end
  end

  assign bank_chip_select    = bank_chip_select_ff;
  assign mem_addr            = mem_addr_ff;
  assign mem_data_out        = mem_data_out_ff;
  assign byte_lane_select_n  = byte_lane_select_n_ff;
  assign mem_output_strobe_n = mem_output_strobe_n_ff;
  assign mem_write_strobe_n  = mem_write_strobe_n_ff;
  assign mem_data_oe_n       = mem_data_oe_n_ff;
  assign hready_out          = hready_out_ff;
  assign hresp               = hresp_ff;
  assign hrdata              = {rdata_ff[3], rdata_ff[2], rdata_ff[1], rdata_ff[0]};
  assign busy                = busy_ff;

  // Checks
  logic [3:0] dly_seen_ff;
  logic [4:0] acc_seen_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dly_seen_ff <= 4'h0;
      acc_seen_ff <= 5'h00;
    end else begin
      dly_seen_ff <= (state_ff == ST_DLY) ? dly_seen_ff + 4'h1 : 4'h0;
      acc_seen_ff <= (state_ff == ST_ACC) ? acc_seen_ff + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_cs_onehot;
    (state_ff == ST_ACC && cs_pol_ff == '0) |-> (~bank_chip_select_ff == (8'h01 << bank_ff));
  endproperty
  a_cs_onehot: assert property (p_cs_onehot) else $error("chip select not one-hot for bank");
  property p_cs_idle;
    (state_ff == ST_IDLE) |-> (bank_chip_select_ff == ~$past(cs_pol_ff));
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("idle chip select not at inactive level");
  property p_dly_len;
    (state_ff == ST_DLY && nxt_state != ST_DLY) |-> (dly_seen_ff + 4'h1 == f_dly) && mem_output_strobe_n_ff
      && mem_write_strobe_n_ff ##1 !(mem_output_strobe_n_ff && mem_write_strobe_n_ff);
  endproperty
  a_dly_len: assert property (p_dly_len) else $error("strobe delay length wrong");
  property p_wst_len;
    (state_ff == ST_ACC && nxt_state != ST_ACC && !cfg_now[`SMCW_F_WAITEN]) |-> acc_seen_ff == wst_cur_ff;
  endproperty
  a_wst_len: assert property (p_wst_len) else $error("wait state count wrong");
  property p_turn_idle;
    (state_ff == ST_TURN) |-> (bank_chip_select_ff == ~$past(cs_pol_ff)) && mem_output_strobe_n_ff && mem_write_strobe_n_ff;
  endproperty
  a_turn_idle: assert property (p_turn_idle) else $error("bus active during turnaround");
  property p_sync;
    (state_ff != ST_BOOT) |-> wait_s2 == $past(ext_wait_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("wait synchroniser depth wrong");
  property p_blank;
    (state_ff == ST_ACC && nxt_state == ST_XWAIT) |-> cs_age_ff >= `SMCW_WAIT_BLANK;
  endproperty
  a_blank: assert property (p_blank) else $error("wait recognised too soon after select");
  property p_countdown;
    (state_ff == ST_ACC && !wait_seen && cnt_ff != 5'h00) |=> state_ff == ST_ACC && cnt_ff == $past(cnt_ff) - 5'h01;
  endproperty
  a_countdown: assert property (p_countdown) else $error("wait count not counting down");
  property p_nowait;
    (state_ff == ST_ACC && !wait_seen && cnt_ff == 5'h00) |=> state_ff == (write_ff ? ST_NEXT : ST_RCAP);
  endproperty
  a_nowait: assert property (p_nowait) else $error("access not completed at count expiry");
  property p_hold;
    (state_ff == ST_XWAIT && wait_act) |=> state_ff == ST_XWAIT && (!mem_output_strobe_n_ff || !mem_write_strobe_n_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("access released while wait active");
  property p_w8_lanes;
    (in_beat_c && f_width == `SMCW_W8) |-> byte_lane_select_n_ff[3:1] == 3'h7;
  endproperty
  a_w8_lanes: assert property (p_w8_lanes) else $error("upper lanes used on narrow bank");
  property p_wprot;
    (state_ff == ST_CFG && write_ff && cfg_rd_data[`SMCW_F_WPROT]) |=> (state_ff == ST_ERR1 && mem_write_strobe_n_ff)
      ##1 (hresp_ff == `SMCW_HRESP_ERROR && hready_out_ff);
  endproperty
  a_wprot: assert property (p_wprot) else $error("protected write not refused");
  property p_boot;
    boot_wr |-> wr_cfg[`SMCW_F_WIDTH_HI:`SMCW_F_WIDTH_LO] == strap_s2;
  endproperty
  a_boot: assert property (p_boot) else $error("boot width not taken from strap");
  property p_burst;
    (state_ff == ST_ACC && !write_ff && cur_cfg_ff[`SMCW_F_BURST] && subseq_ff)
      |-> wst_cur_ff == cur_cfg_ff[`SMCW_F_WSTB_HI:`SMCW_F_WSTB_LO];
  endproperty
  a_burst: assert property (p_burst) else $error("burst follow-on wait count not used");

  c_write:  cover property (state_ff == ST_ACC && write_ff ##1 state_ff == ST_NEXT);
  c_xwait:  cover property (state_ff == ST_XWAIT ##1 state_ff == ST_RCAP);
  c_err:    cover property (state_ff == ST_ERR1 ##1 state_ff == ST_ERR2);
  c_burst:  cover property (state_ff == ST_ACC && subseq_ff && !write_ff);
  c_narrow: cover property (state_ff == ST_NEXT && beat_ff == 2'h3);

endmodule

// ### test/smcw_mem_model.sv
module smcw_mem_model (
  // Clock
  input  wire logic        clk,
  // Memory pins
  input  wire logic [25:0] mem_addr,
  input  wire logic        mem_output_strobe_n,
  input  wire logic        mem_write_strobe_n,
  input  wire logic [31:0] mem_data_out,
  output logic      [31:0] mem_data_in,
  output logic             ext_wait_in,
  // Slow device setting
  input  wire logic [3:0]  wait_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem_q [16];
  logic [31:0] last_q = 32'h0;
  logic [3:0]  wcnt_q = 4'h0;
  logic        act_q  = 1'b0;
  always @(posedge clk) begin
    act_q <= !(mem_output_strobe_n && mem_write_strobe_n);
    if (!mem_write_strobe_n) mem_q[mem_addr[3:0]] <= mem_data_out;
    if (!mem_output_strobe_n) last_q <= mem_q[mem_addr[3:0]];
    if (!act_q && !(mem_output_strobe_n && mem_write_strobe_n)) wcnt_q <= wait_len;
    else if (wcnt_q != 4'h0) wcnt_q <= wcnt_q - 4'h1;
  end
  // Released bus shows the inverse of its last value
  assign mem_data_in = !mem_output_strobe_n ? mem_q[mem_addr[3:0]] : ~last_q;
  assign ext_wait_in = wcnt_q != 4'h0;
endmodule

// ### test/smcw_static_mem_ctrl_test.sv
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end

module smcw_static_mem_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, reset = 1'b1, memory_space_select = 1'b0, hwrite = 1'b0, hready_in = 1'b1;
  logic        cfg_wr_en = 1'b0, endian_select = 1'b0, hready_out, mem_output_strobe_n, mem_write_strobe_n;
  logic        mem_data_oe_n, ext_wait_in, busy;
  logic [1:0]  htrans = 2'h0, boot_width_strap = 2'h2, hresp;
  logic [2:0]  hsize = 3'h2, cfg_wr_bank = 3'h0;
  logic [28:0] haddr = 29'h0;
  logic [31:0] hwdata = 32'h0, cfg_wr_data = 32'h0, hrdata, mem_data_in, mem_data_out;
  logic [25:0] mem_addr;
  logic [7:0]  bank_chip_select, cs_seen;
  logic [3:0]  byte_lane_select_n, wait_len = 4'h0;
  int          mismatches = 0, samples_checked = 0, nstb = 0, n, n0, k, b;

  smcw_static_mem_ctrl uut (.clk, .reset, .memory_space_select, .htrans, .hwrite, .hsize, .haddr, .hwdata,
    .hready_in, .hready_out, .hrdata, .hresp, .cfg_wr_en, .cfg_wr_bank, .cfg_wr_data, .boot_width_strap,
    .endian_select, .bank_chip_select, .mem_addr, .mem_output_strobe_n, .mem_write_strobe_n,
    .byte_lane_select_n, .mem_data_in, .mem_data_out, .mem_data_oe_n, .ext_wait_in, .busy);
  smcw_mem_model mem (.clk, .mem_addr, .mem_output_strobe_n, .mem_write_strobe_n, .mem_data_out,
    .mem_data_in, .ext_wait_in, .wait_len);

  initial forever #20 clk = ~clk;
  always @(negedge clk) if (!mem_write_strobe_n) cs_seen = bank_chip_select;
  always @(negedge mem_write_strobe_n) nstb++;

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wait_rdy();
    for (n = 0; n < 300; n++) begin
      @(negedge clk);
      if (hready_out === 1'b1) return;
    end
    mismatches++;
    end_of_test();
  endtask

  // Address phase held until taken, then data phase
  task automatic xfer(input logic w, input logic [28:0] a, input logic [31:0] d);
    @(posedge clk);
    memory_space_select <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    @(posedge clk);
    memory_space_select <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic cfg(input logic [2:0] bk, input logic [31:0] d);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_bank <= bk;
    cfg_wr_data <= d;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    `CHK(bank_chip_select, 8'hFF)
    wait_rdy();
    for (b = 0; b < 8; b++) begin
      xfer(1'b1, {b[2:0], 26'h4}, 32'hC0DE0000 + b);
      `CHK(cs_seen, ~(8'h01 << b))
      xfer(1'b0, {b[2:0], 26'h4}, 32'h0);
      `CHK(hrdata, 32'hC0DE0000 + b)
    end
    xfer(1'b1, 29'h08000000, 32'h1);
    n0 = n;
    cfg(3'h2, 32'h03E00002);
    xfer(1'b1, 29'h08000000, 32'h1);
    `CHK(n, n0 + 31)
    cfg(3'h2, 32'h03E0F002);
    xfer(1'b1, 29'h08000000, 32'h1);
    `CHK(n, n0 + 46)
    cfg(3'h2, 32'h03E0FF02);
    cfg(3'h1, 32'h00000F02);
    xfer(1'b1, 29'h04000000, 32'h1);
    xfer(1'b1, 29'h08000000, 32'h1);
    `CHK(n, n0 + 61)
    cfg(3'h3, 32'h00000012);
    `CHK(bank_chip_select, 8'hF7)
    cfg(3'h5, 32'h0000000A);
    k = nstb;
    xfer(1'b1, 29'h14000000, 32'h5);
    `CHK(hresp, 2'h1)
    `CHK(nstb, k)
    cfg(3'h4, 32'h00000000);
    k = nstb;
    xfer(1'b1, 29'h10000010, 32'h89ABCDEF);
    `CHK(nstb, k + 4)
    xfer(1'b0, 29'h10000010, 32'h0);
    `CHK(hrdata, 32'h89ABCDEF)
    cfg(3'h6, 32'h00650062);
    xfer(1'b1, 29'h18000000, 32'h600D);
    xfer(1'b0, 29'h18000000, 32'h0);
    `CHK(n, 10)
    k = n;
    wait_len <= 4'hC;
    xfer(1'b0, 29'h18000000, 32'h0);
    `CHK(n > k + 5, 1'b1)
    `CHK(hrdata, 32'h600D)
    cfg(3'h7, 32'h08080005);
    xfer(1'b0, 29'h1C000000, 32'h0);
    `CHK(n, 19)
    `CHK(hrdata, 32'hABCD600D)
    end_of_test();
  end
endmodule
